// File: rtl/pll_clock_consts.vh
/*
  Register indices, field positions and reset values for the dual PLL
  clock select block. Included by the top design file; definitions only.
*/
`ifndef PLL_CLOCK_CONSTS_VH
`define PLL_CLOCK_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_PLL_A_FRAC_LOW 6'h00
`define IDX_PLL_A_FRAC_MID 6'h01
`define IDX_PLL_A_FRAC_HIGH_INT 6'h02
`define IDX_PLL_A_DIVIDERS 6'h03
`define IDX_PLL_B_FRAC_LOW 6'h04
`define IDX_PLL_B_FRAC_MID 6'h05
`define IDX_PLL_B_FRAC_HIGH_INT 6'h06
`define IDX_PLL_B_DIVIDERS_PIN_SRC 6'h07
`define IDX_CLOCK_SOURCE_SELECT 6'h08
`define IDX_MODE_CONTROL 6'h20
`define IDX_ROUTING_STATUS 6'h21

// Reset values of the nine-bit registers and the two-bit mode register
`define RST_FRAC_LOW 9'h121
`define RST_FRAC_MID 9'h17e
`define RST_FRAC_HIGH_INT 9'h07d
`define RST_PLL_A_DIVIDERS 9'h010
`define RST_PLL_B_DIVIDERS_PIN_SRC 9'h190
`define RST_CLOCK_SOURCE_SELECT 9'h000
`define RST_MODE_CONTROL 2'h0

// Field positions
`define FRAC_HIGH_MSB 3
`define INT_MSB 7
`define INT_LSB 4
`define IN_HALVE_BIT 0
`define OUT_HALVE_BIT 1
`define OUT_DIV_MSB 4
`define OUT_DIV_LSB 3
`define MASTER_SRC_MSB 6
`define MASTER_SRC_LSB 5
`define CLOCK_OUTPUT_PIN_SRC_MSB 8
`define CLOCK_OUTPUT_PIN_SRC_LSB 7
`define DAC_SRC_MSB 1
`define DAC_SRC_LSB 0
`define MANUAL_ROUTING_BIT 6
`define CONT_READBACK_BIT 0
`define RX_LOCKED_BIT 1

// Source encodings shared by pin and DAC selects
`define SRC_MASTER_PIN 2'h0
`define SRC_PLL_A 2'h1
`define SRC_PLL_B 2'h2
`define SRC_OSC 2'h3

`endif

// File: rtl/pll_output_control.v
/*
  Output divider control for one PLL: picks the stored or automatic
  post-scale and output divider settings depending on the PLL mode.
  Assumes inputs are stable register values in the clk domain.
*/
`timescale 1ns/1ns
module pll_output_control #(
	parameter PRIMARY = 1
) (
	input wire rxLocked,
	input wire storedHalve,
	input wire [1:0] storedDivider,
	input wire [1:0] autoDivider,
	output reg effHalve,
	output reg [1:0] effDivider,
	output reg controlsUsed
);

	// Receiver mode: primary keeps its halve bit, divider is automatic
	always @* begin
		if (!rxLocked) begin
			effHalve = storedHalve;
			effDivider = storedDivider;
			controlsUsed = 1'b1;
		end else if (PRIMARY != 0) begin
			effHalve = storedHalve;
			effDivider = autoDivider;
			controlsUsed = 1'b1;
		end else begin
			// Secondary settings are ignored in this mode
			effHalve = 1'b0;
			effDivider = 2'h0;
			controlsUsed = 1'b0;
		end
	end

endmodule

// File: rtl/dual_pll_clock_select.v
/*
  Configuration registers for two fractional PLLs plus master clock pin,
  clock output pin and DAC clock routing, reached over APB.
  Assumes APB signals synchronous to clk; the PLL cores, the pin pads
  and the automatic routing logic sit outside and use the outputs here.
  Register contents live in flops and leave through one read multiplexer;
  the mode and status words sit at indices of their own.
  Software-side limits on ratios and pre-scale bits are not enforced here;
  out-of-range values pass straight to the PLL cores.
*/
// Operation
// - PLL A fraction split over three registers
// - Reads of first two offsets return identity
// - Read of third offset returns revision
// - Continuous readback disables identity readback
// - Input halve bit divides reference by two
// - Receiver mode: A halve used, B ignored
// - Receiver mode: A divider automatic, B ignored
// - User mode: halve plus divider set output
// - PLL B ratio uses same layout
// - Master pin input or sourced clock
// - Clock output pin tristate or sourced clock
// - DAC clock source select
// - Manual override chooses explicit routing fields
`timescale 1ns/1ns
`include "pll_clock_consts.vh"
module dual_pll_clock_select #(
	parameter [7:0] DEVICE_ID_LOW = 8'h5a, // Arbitrary value
	parameter [7:0] DEVICE_ID_HIGH = 8'h3c, // Arbitrary value
	parameter [7:0] DEVICE_REVISION = 8'h01 // Arbitrary value
) (
	input wire clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [1:0] autoDividerA,
	input wire [1:0] autoMasterSource,
	input wire [1:0] autoClockOutSource,
	input wire [1:0] autoDacSource,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg [25:0] pllARatio,
	output reg pllAInputHalve,
	output reg pllAOutputHalve,
	output reg [1:0] pllAOutDivider,
	output reg [25:0] pllBRatio,
	output reg pllBInputHalve,
	output reg pllBOutputHalve,
	output reg [1:0] pllBOutDivider,
	output reg pllBOutputControlsUsed,
	output reg masterPinOe,
	output reg [1:0] masterPinSource,
	output reg clockOutPinOe,
	output reg [1:0] clockOutPinSource,
	output reg [1:0] dacClockSource,
	output reg receiverLocked
);

	// Stored register contents
	reg [8:0] pllAFracLow;
	reg [8:0] pllAFracMid;
	reg [8:0] pllAFracHighInt;
	reg [8:0] pllADividers;
	reg [8:0] pllBFracLow;
	reg [8:0] pllBFracMid;
	reg [8:0] pllBFracHighInt;
	reg [8:0] pllBDividersPinSrc;
	reg [8:0] clockSourceSelect;
	reg [1:0] modeControl;

	// Decoded bus request
	wire [5:0] regIndex;
	wire addrAligned;
	wire accessDone;
	wire writeStrobe;
	reg regMapped;
	reg [8:0] readValue;
	wire [8:0] statusWord;

	// Field views of the stored registers
	wire [21:0] pllAFraction;
	wire [3:0] pllAInteger;
	wire [21:0] pllBFraction;
	wire [3:0] pllBInteger;
	wire continuousReadback;
	wire rxMode;
	wire manualClockRouting;
	wire [1:0] storedMasterSource;
	wire [1:0] storedClockOutSource;
	wire [1:0] storedDacSource;

	// Effective values before the output flops
	wire next_pllAOutputHalve;
	wire [1:0] next_pllAOutDivider;
	wire next_pllBOutputHalve;
	wire [1:0] next_pllBOutDivider;
	wire next_pllBUsed;
	reg [1:0] next_masterPinSource;
	reg [1:0] next_clockOutPinSource;
	reg [1:0] next_dacClockSource;

	// Word addressing; low two address bits must be zero
	assign regIndex = paddr[7:2];
	assign addrAligned = (paddr[1:0] == 2'h0);

	// Single wait state: pready is a flop raised in the access phase
	assign accessDone = psel & penable & pready;
	assign writeStrobe = accessDone & pwrite & regMapped;

	// Fraction and integer fields gathered across registers
	assign pllAFraction = {pllAFracHighInt[`FRAC_HIGH_MSB:0], pllAFracMid,
		pllAFracLow};
	assign pllAInteger = pllAFracHighInt[`INT_MSB:`INT_LSB];
	assign pllBFraction = {pllBFracHighInt[`FRAC_HIGH_MSB:0], pllBFracMid,
		pllBFracLow};
	assign pllBInteger = pllBFracHighInt[`INT_MSB:`INT_LSB];

	// Mode and routing fields
	assign continuousReadback = modeControl[`CONT_READBACK_BIT];
	assign rxMode = modeControl[`RX_LOCKED_BIT];
	assign manualClockRouting = clockSourceSelect[`MANUAL_ROUTING_BIT];
	assign storedMasterSource = pllBDividersPinSrc[`MASTER_SRC_MSB:`MASTER_SRC_LSB];
	assign storedClockOutSource = pllBDividersPinSrc[`CLOCK_OUTPUT_PIN_SRC_MSB:`CLOCK_OUTPUT_PIN_SRC_LSB];
	assign storedDacSource = clockSourceSelect[`DAC_SRC_MSB:`DAC_SRC_LSB];

	// Status word; the two top bits are spare and read as zero
	assign statusWord = {2'b00, pllBOutputControlsUsed, dacClockSource,
		clockOutPinSource, masterPinSource};

	// Address decode; unmapped indices answer with an error
	// Misaligned addresses are refused rather than rounded down
	always @* begin
		if (!addrAligned) begin
			regMapped = 1'b0;
		end else if (regIndex <= `IDX_CLOCK_SOURCE_SELECT) begin
			regMapped = 1'b1;
		end else if (regIndex == `IDX_MODE_CONTROL) begin
			regMapped = 1'b1;
		end else if (regIndex == `IDX_ROUTING_STATUS) begin
			regMapped = 1'b1;
		end else begin
			regMapped = 1'b0;
		end
	end

	// Read multiplexer; identity words shadow the stored fraction bits
	// Continuous readback also opens the revision index to stored bits
	always @* begin
		if (!regMapped) begin
			readValue = 9'h000;
		end else if (regIndex == `IDX_PLL_A_FRAC_LOW) begin
			if (continuousReadback) begin
				readValue = pllAFracLow;
			end else begin
				readValue = {1'b0, DEVICE_ID_LOW};
			end
		end else if (regIndex == `IDX_PLL_A_FRAC_MID) begin
			if (continuousReadback) begin
				readValue = pllAFracMid;
			end else begin
				readValue = {1'b0, DEVICE_ID_HIGH};
			end
		end else if (regIndex == `IDX_PLL_A_FRAC_HIGH_INT) begin
			if (continuousReadback) begin
				readValue = pllAFracHighInt;
			end else begin
				readValue = {1'b0, DEVICE_REVISION};
			end
		end else if (regIndex == `IDX_PLL_A_DIVIDERS) begin
			readValue = pllADividers;
		end else if (regIndex == `IDX_PLL_B_FRAC_LOW) begin
			readValue = pllBFracLow;
		end else if (regIndex == `IDX_PLL_B_FRAC_MID) begin
			readValue = pllBFracMid;
		end else if (regIndex == `IDX_PLL_B_FRAC_HIGH_INT) begin
			readValue = pllBFracHighInt;
		end else if (regIndex == `IDX_PLL_B_DIVIDERS_PIN_SRC) begin
			readValue = pllBDividersPinSrc;
		end else if (regIndex == `IDX_CLOCK_SOURCE_SELECT) begin
			readValue = clockSourceSelect;
		end else if (regIndex == `IDX_MODE_CONTROL) begin
			readValue = {7'h00, modeControl};
		end else begin
			// Live routing state as it leaves the block
			readValue = statusWord;
		end
	end

	// APB handshake and read data, both from flops
	// The !pready term ends each answer after one cycle; a held access phase answers again two cycles later
	always @(posedge clk) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= ~regMapped;
			prdata <= {23'h00_0000, readValue};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Register writes take effect only at the completing edge
	// Unmapped, misaligned and status writes change nothing
	always @(posedge clk) begin
		if (!rst_b) begin
			pllAFracLow <= `RST_FRAC_LOW;
			pllAFracMid <= `RST_FRAC_MID;
			pllAFracHighInt <= `RST_FRAC_HIGH_INT;
			pllADividers <= `RST_PLL_A_DIVIDERS;
			pllBFracLow <= `RST_FRAC_LOW;
			pllBFracMid <= `RST_FRAC_MID;
			pllBFracHighInt <= `RST_FRAC_HIGH_INT;
			pllBDividersPinSrc <= `RST_PLL_B_DIVIDERS_PIN_SRC;
			clockSourceSelect <= `RST_CLOCK_SOURCE_SELECT;
			modeControl <= `RST_MODE_CONTROL;
		end else if (writeStrobe) begin
			if (regIndex == `IDX_PLL_A_FRAC_LOW) begin
				pllAFracLow <= pwdata[8:0];
			end else if (regIndex == `IDX_PLL_A_FRAC_MID) begin
				pllAFracMid <= pwdata[8:0];
			end else if (regIndex == `IDX_PLL_A_FRAC_HIGH_INT) begin
				// Bit 8 has no field; kept zero
				pllAFracHighInt <= {1'b0, pwdata[7:0]};
			end else if (regIndex == `IDX_PLL_A_DIVIDERS) begin
				pllADividers <= {4'h0, pwdata[4:0]};
			end else if (regIndex == `IDX_PLL_B_FRAC_LOW) begin
				pllBFracLow <= pwdata[8:0];
			end else if (regIndex == `IDX_PLL_B_FRAC_MID) begin
				pllBFracMid <= pwdata[8:0];
			end else if (regIndex == `IDX_PLL_B_FRAC_HIGH_INT) begin
				pllBFracHighInt <= {1'b0, pwdata[7:0]};
			end else if (regIndex == `IDX_PLL_B_DIVIDERS_PIN_SRC) begin
				// Bit 2 has no field
				pllBDividersPinSrc <= {pwdata[8:3], 1'b0, pwdata[1:0]};
			end else if (regIndex == `IDX_CLOCK_SOURCE_SELECT) begin
				// Only the DAC select and override are held here
				clockSourceSelect <= {2'h0, pwdata[6], 4'h0, pwdata[1:0]};
			end else if (regIndex == `IDX_MODE_CONTROL) begin
				modeControl <= pwdata[1:0];
			end
		end
	end

	// PLL A output controls
	pll_output_control #(
		.PRIMARY(1)
	) pllAControl (
		.rxLocked(rxMode),
		.storedHalve(pllADividers[`OUT_HALVE_BIT]),
		.storedDivider(pllADividers[`OUT_DIV_MSB:`OUT_DIV_LSB]),
		.autoDivider(autoDividerA),
		.effHalve(next_pllAOutputHalve),
		.effDivider(next_pllAOutDivider),
		.controlsUsed()
	);

	// PLL B output controls; ignored while receiver locked
	// No automatic divider exists for the secondary PLL; tied to zero
	pll_output_control #(
		.PRIMARY(0)
	) pllBControl (
		.rxLocked(rxMode),
		.storedHalve(pllBDividersPinSrc[`OUT_HALVE_BIT]),
		.storedDivider(pllBDividersPinSrc[`OUT_DIV_MSB:`OUT_DIV_LSB]),
		.autoDivider(2'h0),
		.effHalve(next_pllBOutputHalve),
		.effDivider(next_pllBOutDivider),
		.controlsUsed(next_pllBUsed)
	);

	// Routing: automatic unless the override bit is set
	// Manual codes pass as given except DAC code 3; nothing checks that the chosen PLL runs
	always @* begin
		if (manualClockRouting) begin
			next_masterPinSource = storedMasterSource;
			next_clockOutPinSource = storedClockOutSource;
			next_dacClockSource = storedDacSource;
		end else begin
			next_masterPinSource = autoMasterSource;
			next_clockOutPinSource = autoClockOutSource;
			next_dacClockSource = autoDacSource;
		end
		// Both ends of the DAC code mean the master pin
		if (next_dacClockSource == `SRC_OSC) begin
			next_dacClockSource = `SRC_MASTER_PIN;
		end
	end

	// Registered configuration outputs to PLL cores and pads
	// Each enable and its source share one next value, so they never disagree
	always @(posedge clk) begin
		if (!rst_b) begin
			pllARatio <= 26'h000_0000;
			pllAInputHalve <= 1'b0;
			pllAOutputHalve <= 1'b0;
			pllAOutDivider <= 2'h0;
			pllBRatio <= 26'h000_0000;
			pllBInputHalve <= 1'b0;
			pllBOutputHalve <= 1'b0;
			pllBOutDivider <= 2'h0;
			pllBOutputControlsUsed <= 1'b0;
			masterPinOe <= 1'b0;
			masterPinSource <= `SRC_MASTER_PIN;
			clockOutPinOe <= 1'b0;
			clockOutPinSource <= `SRC_MASTER_PIN;
			dacClockSource <= `SRC_MASTER_PIN;
			receiverLocked <= 1'b0;
		end else begin
			// Fixed point: integer above 22 fraction bits
			pllARatio <= {pllAInteger, pllAFraction};
			pllBRatio <= {pllBInteger, pllBFraction};
			pllAInputHalve <= pllADividers[`IN_HALVE_BIT];
			pllBInputHalve <= pllBDividersPinSrc[`IN_HALVE_BIT];
			pllAOutputHalve <= next_pllAOutputHalve;
			pllAOutDivider <= next_pllAOutDivider;
			pllBOutputHalve <= next_pllBOutputHalve;
			pllBOutDivider <= next_pllBOutDivider;
			pllBOutputControlsUsed <= next_pllBUsed;
			// Code 00 leaves the master pin as an input
			masterPinOe <= (next_masterPinSource != `SRC_MASTER_PIN);
			masterPinSource <= next_masterPinSource;
			// Code 00 tristates the clock output pin
			clockOutPinOe <= (next_clockOutPinSource != `SRC_MASTER_PIN);
			clockOutPinSource <= next_clockOutPinSource;
			dacClockSource <= next_dacClockSource;
			receiverLocked <= rxMode;
		end
	end

endmodule

// File: dv/dual_pll_clock_select_props.sv
/* Checker for the dual PLL clock select block, bound to its top module.
   Assumes one clock, synchronous active-low reset and APB with one wait. */
`timescale 1ns/1ns
module dual_pll_clock_select_props (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic [1:0] autoDividerA,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] pllAOutDivider,
	input wire logic pllBOutputHalve,
	input wire logic [1:0] pllBOutDivider,
	input wire logic pllBOutputControlsUsed,
	input wire logic masterPinOe,
	input wire logic [1:0] masterPinSource,
	input wire logic clockOutPinOe,
	input wire logic [1:0] clockOutPinSource,
	input wire logic [1:0] dacClockSource,
	input wire logic receiverLocked
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Bus answer: one wait, one-cycle pulse, refusals carry no data
	access_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("answer not after exactly one wait");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	refused_read_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error response without ready or with data");
	upper_zero_a: assert property (pready |-> prdata[31:9] == 23'h0)
		else $error("read data upper bits not zero");
	// Pin enables track the source codes; 00 means input or tristate
	master_oe_a: assert property (masterPinOe == (masterPinSource != 2'h0))
		else $error("master pin enable disagrees with source");
	clock_output_pin_oe_a: assert property (clockOutPinOe == (clockOutPinSource != 2'h0))
		else $error("clock output enable disagrees with source");
	dac_code_a: assert property (dacClockSource != 2'h3)
		else $error("DAC source code 3 must fold to master pin");
	// Receiver mode: second PLL controls dropped, first divider automatic
	rx_b_ignored_a: assert property (receiverLocked [*2] |->
		!pllBOutputControlsUsed && !pllBOutputHalve && pllBOutDivider == 2'h0)
		else $error("second PLL output controls used in receiver mode");
	rx_a_auto_a: assert property ((receiverLocked && $stable(autoDividerA)) [*3] |->
		pllAOutDivider == autoDividerA)
		else $error("first PLL divider not automatic in receiver mode");
	reset_quiet_a: assert property (disable iff (1'b0) !rst_b |=> !pready && !masterPinOe)
		else $error("outputs active after reset cycle");
	cover property (pready && pslverr);
	cover property (receiverLocked [*3]);
	cover property (masterPinOe && clockOutPinOe);
endmodule
bind dual_pll_clock_select dual_pll_clock_select_props dual_pll_clock_select_props_inst (
	.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .autoDividerA(autoDividerA),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pllAOutDivider(pllAOutDivider),
	.pllBOutputHalve(pllBOutputHalve), .pllBOutDivider(pllBOutDivider),
	.pllBOutputControlsUsed(pllBOutputControlsUsed), .masterPinOe(masterPinOe),
	.masterPinSource(masterPinSource), .clockOutPinOe(clockOutPinOe),
	.clockOutPinSource(clockOutPinSource), .dacClockSource(dacClockSource),
	.receiverLocked(receiverLocked)
);

// File: dv/testbench.sv
/* Self-checking bench for the dual PLL clock select block.
   Assumes the design files compile first; drives APB as master. */
`timescale 1ns/1ns
module testbench;
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [1:0] autoDividerA = 0, autoMasterSource = 0, autoClockOutSource = 0;
	logic [1:0] autoDacSource = 0;
	wire [31:0] prdata;
	wire pready, pslverr, pllAInputHalve, pllAOutputHalve, pllBInputHalve, pllBOutputHalve;
	wire pllBOutputControlsUsed, masterPinOe, clockOutPinOe, receiverLocked;
	wire [25:0] pllARatio, pllBRatio;
	wire [1:0] pllAOutDivider, pllBOutDivider, masterPinSource, clockOutPinSource, dacClockSource;
	int fail_count = 0, total_checks = 0;
	typedef struct {logic [7:0] a; logic [8:0] d, w, r;} row_t;
	// Address, reset value, write value, expected readback
	row_t rows[9] = '{'{8'h00, 9'h121, 9'h1a5, 9'h1a5}, '{8'h04, 9'h17e, 9'h0f3, 9'h0f3},
		'{8'h08, 9'h07d, 9'h1b6, 9'h0b6}, '{8'h0c, 9'h010, 9'h1ff, 9'h01f},
		'{8'h10, 9'h121, 9'h155, 9'h155}, '{8'h14, 9'h17e, 9'h0aa, 9'h0aa},
		'{8'h18, 9'h07d, 9'h1c9, 9'h0c9}, '{8'h1c, 9'h190, 9'h1ff, 9'h1fb},
		'{8'h20, 9'h000, 9'h1ff, 9'h043}};
	dual_pll_clock_select dual_pll_clock_select_inst (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.autoDividerA(autoDividerA), .autoMasterSource(autoMasterSource),
		.autoClockOutSource(autoClockOutSource), .autoDacSource(autoDacSource),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pllARatio(pllARatio),
		.pllAInputHalve(pllAInputHalve), .pllAOutputHalve(pllAOutputHalve),
		.pllAOutDivider(pllAOutDivider), .pllBRatio(pllBRatio),
		.pllBInputHalve(pllBInputHalve), .pllBOutputHalve(pllBOutputHalve),
		.pllBOutDivider(pllBOutDivider), .pllBOutputControlsUsed(pllBOutputControlsUsed),
		.masterPinOe(masterPinOe), .masterPinSource(masterPinSource),
		.clockOutPinOe(clockOutPinOe), .clockOutPinSource(clockOutPinSource),
		.dacClockSource(dacClockSource), .receiverLocked(receiverLocked));
	always #4 clk = ~clk;
	// One APB transfer; request held until ready is sampled
	task xfer(input [7:0] a, input w, input [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk);
		end
		if (n == 50) fail_count++;
		rd = prdata; err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task chk(input string nm, input [32:0] e, input [32:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Derived outputs lag the register by one cycle
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		conclude;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1;
		xfer(8'h80, 1, 32'h0000_0001);
		foreach (rows[i]) begin
			xfer(rows[i].a, 0, 0);
			chk("reset value", {23'h0, rows[i].d}, rd);
			xfer(rows[i].a, 1, {23'h0, rows[i].w});
			xfer(rows[i].a, 0, 0);
			chk("readback", {23'h0, rows[i].r}, rd);
		end
		settle;
		chk("ratio A", {4'hb, 4'h6, 9'h0f3, 9'h1a5}, pllARatio);
		chk("ratio B", {4'hc, 4'h9, 9'h0aa, 9'h155}, pllBRatio);
		chk("halves", 4'hf, {pllAInputHalve, pllAOutputHalve, pllBInputHalve, pllBOutputHalve});
		chk("dividers", 5'h1f, {pllBOutputControlsUsed, pllAOutDivider, pllBOutDivider});
		// Identity readback once continuous readback is off
		xfer(8'h80, 1, 0);
		xfer(8'h00, 0, 0);
		chk("id low", 32'h0000_005a, rd);
		xfer(8'h04, 0, 0);
		chk("id high", 32'h0000_003c, rd);
		xfer(8'h08, 0, 0);
		chk("revision", 32'h0000_0001, rd);
		for (int c = 0; c < 4; c++) begin
			xfer(8'h1c, 1, {23'h0, c[1:0], c[1:0], 5'h1b});
			xfer(8'h20, 1, {23'h0, 7'h10, c[1:0]});
			settle;
			chk("pins", {c[1:0], c != 0, c[1:0], c != 0}, {masterPinSource, masterPinOe,
				clockOutPinSource, clockOutPinOe});
			chk("dac", (c == 3) ? 0 : c, dacClockSource);
		end
		xfer(8'h20, 1, 0);
		autoMasterSource <= 2; autoClockOutSource <= 1; autoDacSource <= 3; autoDividerA <= 2;
		settle;
		chk("auto route", 6'h24, {masterPinSource, clockOutPinSource, dacClockSource});
		xfer(8'h84, 0, 0);
		chk("status", 32'h0000_0046, rd);
		// Receiver mode wants a fixed PLL B ratio and equal input halves
		xfer(8'h10, 1, 32'h0000_0121);
		xfer(8'h14, 1, 32'h0000_017e);
		xfer(8'h18, 1, 32'h0000_007d);
		xfer(8'h80, 1, 32'h0000_0003);
		repeat (3) settle;
		chk("ratio B rx", {4'h7, 4'hd, 9'h17e, 9'h121}, pllBRatio);
		chk("rx mode", 7'h70, {receiverLocked, pllAOutputHalve, pllAOutDivider,
			pllBOutputHalve, pllBOutDivider});
		xfer(8'h80, 1, 32'h0000_0001);
		settle;
		chk("user div", 2'h3, pllAOutDivider);
		xfer(8'h40, 1, 32'h0000_01ff);
		chk("unmapped", 33'h1_0000_0000, {err, rd});
		xfer(8'h0d, 1, 0);
		chk("misaligned err", 1, err);
		xfer(8'h0c, 0, 0);
		chk("misaligned", 33'h0_0000_001f, {err, rd});
		@(posedge clk);
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		xfer(8'h0c, 0, 0);
		chk("second reset", 32'h0000_0010, rd);
		conclude;
	end
endmodule
